// [core/uv_fault_handler.sv]
// Purpose: input low-voltage warning/fault supervision with programmable response
// Assumes: commands arrive decoded; time_tick marks one configured time unit
// Notes: ctrl_pin is asynchronous and is filtered by three flip-flops
`timescale 1ns/1ps
module uv_fault_handler
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // command port
    input wire uv_fault_pkg::cmd_t cmd,
    output uv_fault_pkg::rsp_t rsp_q,
    // measurement and timing
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    input wire logic time_tick,
    // on/off and fault clearing
    input wire logic ctrl_pin,
    input wire logic operation_on,
    input wire logic clear_faults,
    input wire logic status_clear,
    input wire logic ratio_mode_enable,
    // outputs
    output logic output_enable_q,
    output logic warn_flag_q,
    output logic fault_flag_q,
    output logic latched_off_q,
    output logic ratio_low_input_q
);

    logic [15:0] warn_threshold_q;
    logic [15:0] fault_threshold_q;
    logic [7:0] fault_action_q;
    logic [2:0] ctrl_sync_q;
    logic ctrl_level_q;
    logic run_req;
    logic below_warn;
    logic below_fault;
    logic seen;
    logic fault_now;
    logic timer_start_q;
    logic timer_busy;
    logic timer_done;
    logic [2:0] attempts_q;
    logic [1:0] resp_code;
    logic [2:0] retry_code;
    logic [2:0] delay_code;
    logic retries_used_up;
    uv_fault_pkg::state_t st_q;

    assign resp_code = fault_action_q[uv_fault_pkg::ACT_RESP_HI:uv_fault_pkg::ACT_RESP_LO];
    assign retry_code = fault_action_q[uv_fault_pkg::ACT_RETRY_HI:uv_fault_pkg::ACT_RETRY_LO];
    assign delay_code = fault_action_q[uv_fault_pkg::ACT_DELAY_HI:uv_fault_pkg::ACT_DELAY_LO];
    assign run_req = ctrl_level_q & operation_on;
    assign fault_now = seen & below_fault;
    // attempt about to start is attempts_q+1; unlimited code never runs out
    assign retries_used_up = (retry_code != uv_fault_pkg::RETRY_FOREVER)
        && ((attempts_q + 3'h1) >= retry_code);

    // ctrl pin filter: change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_sync_q <= 3'h0;
            ctrl_level_q <= 1'b0;
        end
        else
        begin
            ctrl_sync_q <= {ctrl_sync_q[1:0], ctrl_pin};
            if (ctrl_sync_q[1] == ctrl_sync_q[2])
                ctrl_level_q <= ctrl_sync_q[2];
        end
    end

    // register writes
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            warn_threshold_q <= uv_fault_pkg::WARN_THRESHOLD_RST;
            fault_threshold_q <= uv_fault_pkg::FAULT_THRESHOLD_RST;
            fault_action_q <= uv_fault_pkg::FAULT_ACTION_RST;
        end
        else if (cmd.valid && cmd.write)
        begin
            if (cmd.code == uv_fault_pkg::CMD_WARN_THRESHOLD)
                warn_threshold_q <= cmd.wdata;
            else if (cmd.code == uv_fault_pkg::CMD_FAULT_THRESHOLD)
                fault_threshold_q <= cmd.wdata;
            else if (cmd.code == uv_fault_pkg::CMD_FAULT_ACTION)
                fault_action_q <= cmd.wdata[7:0];
        end
    end

    // command answers, one cycle after the command; unknown codes not acked
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= cmd.valid;
            rsp_q.ack <= 1'b0;
            rsp_q.rdata <= 16'h0000;
            if (cmd.valid)
            begin
                if (cmd.code == uv_fault_pkg::CMD_WARN_THRESHOLD)
                begin
                    rsp_q.ack <= 1'b1;
                    rsp_q.rdata <= cmd.write ? 16'h0000 : warn_threshold_q;
                end
                else if (cmd.code == uv_fault_pkg::CMD_FAULT_THRESHOLD)
                begin
                    rsp_q.ack <= 1'b1;
                    rsp_q.rdata <= cmd.write ? 16'h0000 : fault_threshold_q;
                end
                else if (cmd.code == uv_fault_pkg::CMD_FAULT_ACTION)
                begin
                    rsp_q.ack <= 1'b1;
                    rsp_q.rdata <= cmd.write ? 16'h0000 : {8'h00, fault_action_q};
                end
            end
        end
    end

    linear_compare u_compare
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .sample_valid(sample_valid),
        .sample(sample),
        .warn_threshold(warn_threshold_q),
        .fault_threshold(fault_threshold_q),
        .below_warn_q(below_warn),
        .below_fault_q(below_fault),
        .seen_q(seen)
    );

    unit_timer u_timer
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(timer_start_q),
        .field(delay_code),
        .tick(time_tick),
        .busy_q(timer_busy),
        .done_q(timer_done)
    );

    // sticky status flags; a new event wins over a clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            warn_flag_q <= 1'b0;
            fault_flag_q <= 1'b0;
        end
        else
        begin
            if (seen && below_warn)
                warn_flag_q <= 1'b1;
            else if (clear_faults || status_clear)
                warn_flag_q <= 1'b0;
            if (fault_now)
                fault_flag_q <= 1'b1;
            else if (clear_faults || status_clear)
                fault_flag_q <= 1'b0;
        end
    end

    // ratio regulation switches on the warning threshold
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ratio_low_input_q <= 1'b0;
        else
            ratio_low_input_q <= ratio_mode_enable & seen & below_warn;
    end

    // fault response sequencer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q <= uv_fault_pkg::ST_OFF;
            output_enable_q <= 1'b0;
            latched_off_q <= 1'b0;
            timer_start_q <= 1'b0;
            attempts_q <= 3'h0;
        end
        else
        begin
            timer_start_q <= 1'b0;
            case (st_q)
                uv_fault_pkg::ST_OFF:
                begin
                    output_enable_q <= 1'b0;
                    latched_off_q <= 1'b0;
                    attempts_q <= 3'h0;
                    if (run_req)
                    begin
                        st_q <= uv_fault_pkg::ST_RUN;
                        output_enable_q <= 1'b1;
                    end
                end
                uv_fault_pkg::ST_RUN:
                begin
                    attempts_q <= 3'h0;
                    if (!run_req)
                    begin
                        st_q <= uv_fault_pkg::ST_OFF;
                        output_enable_q <= 1'b0;
                    end
                    else if (fault_now)
                    begin
                        case (resp_code)
                            uv_fault_pkg::RESP_IGNORE:
                                st_q <= uv_fault_pkg::ST_RUN;
                            uv_fault_pkg::RESP_DELAY_RUN:
                            begin
                                st_q <= uv_fault_pkg::ST_HOLD_ON;
                                timer_start_q <= 1'b1;
                            end
                            uv_fault_pkg::RESP_DISABLE_RETRY:
                            begin
                                output_enable_q <= 1'b0;
                                if (retry_code == uv_fault_pkg::RETRY_NONE)
                                begin
                                    st_q <= uv_fault_pkg::ST_LATCHED;
                                    latched_off_q <= 1'b1;
                                end
                                else
                                begin
                                    st_q <= uv_fault_pkg::ST_RETRY_WAIT;
                                    timer_start_q <= 1'b1;
                                end
                            end
                            default:
                            begin
                                st_q <= uv_fault_pkg::ST_LATCHED;
                                output_enable_q <= 1'b0;
                                latched_off_q <= 1'b1;
                            end
                        endcase
                    end
                end
                uv_fault_pkg::ST_HOLD_ON:
                begin
                    if (!run_req)
                    begin
                        st_q <= uv_fault_pkg::ST_OFF;
                        output_enable_q <= 1'b0;
                    end
                    else if (!fault_now)
                        st_q <= uv_fault_pkg::ST_RUN;
                    else if (timer_done)
                    begin
                        output_enable_q <= 1'b0;
                        if (retry_code == uv_fault_pkg::RETRY_NONE)
                        begin
                            st_q <= uv_fault_pkg::ST_LATCHED;
                            latched_off_q <= 1'b1;
                        end
                        else
                        begin
                            st_q <= uv_fault_pkg::ST_RETRY_WAIT;
                            timer_start_q <= 1'b1;
                        end
                    end
                end
                uv_fault_pkg::ST_RETRY_WAIT:
                begin
                    if (!run_req)
                        st_q <= uv_fault_pkg::ST_OFF;
                    else if (timer_done)
                    begin
                        // an attempt starts; it fails while the fault persists
                        if (!fault_now)
                        begin
                            st_q <= uv_fault_pkg::ST_RUN;
                            output_enable_q <= 1'b1;
                        end
                        else if (retries_used_up)
                        begin
                            st_q <= uv_fault_pkg::ST_LATCHED;
                            latched_off_q <= 1'b1;
                        end
                        else
                        begin
                            attempts_q <= attempts_q + 3'h1;
                            timer_start_q <= 1'b1;
                        end
                    end
                end
                uv_fault_pkg::ST_LATCHED:
                begin
                    output_enable_q <= 1'b0;
                    if (!run_req)
                    begin
                        st_q <= uv_fault_pkg::ST_OFF;
                        latched_off_q <= 1'b0;
                    end
                    else if (clear_faults || status_clear)
                    begin
                        st_q <= uv_fault_pkg::ST_RUN;
                        output_enable_q <= 1'b1;
                        latched_off_q <= 1'b0;
                    end
                end
                default:
                begin
                    st_q <= uv_fault_pkg::ST_OFF;
                    output_enable_q <= 1'b0;
                end
            endcase
        end
    end

endmodule : uv_fault_handler

// [core/uv_fault_pkg.sv]
// Purpose: shared constants, types and states of the input low-voltage fault handler
// Assumes: command codes arrive already decoded from the management bus framing
// Notes: thresholds use the 16-bit linear number format (5-bit exponent, 11-bit mantissa)
package uv_fault_pkg;

    // command codes of the three supervised registers
    localparam logic [7:0] CMD_WARN_THRESHOLD = 8'h58;
    localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h59;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h5a;

    // linear format field positions
    localparam int LIN_EXP_HI = 15;
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_MANT_HI = 10;
    localparam int LIN_MANT_LO = 0;
    localparam int LIN_FRAC_BITS = 16;

    // action byte field positions
    localparam int ACT_RESP_HI = 7;
    localparam int ACT_RESP_LO = 6;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam int ACT_DELAY_HI = 2;
    localparam int ACT_DELAY_LO = 0;

    // reset values
    localparam logic [15:0] WARN_THRESHOLD_RST = 16'h0000;
    localparam logic [15:0] FAULT_THRESHOLD_RST = 16'h0000;
    localparam logic [7:0] FAULT_ACTION_RST = 8'h00;

    // response codes
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAY_RUN = 2'h1;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] RESP_LATCH_OFF = 2'h3;

    // retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // delay timer: one unit is 2**field time-unit ticks
    localparam logic [7:0] TIMER_ONE = 8'h01;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [15:0] rdata;
    } rsp_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_HOLD_ON,
        ST_RETRY_WAIT,
        ST_LATCHED
    } state_t;

endpackage : uv_fault_pkg

// [core/unit_timer.sv]
// Purpose: counts 1,2,4..128 time-unit ticks after a start pulse
// Assumes: tick is a one-cycle enable on clk_sys marking one time unit
// Notes: a start while busy reloads the count
`timescale 1ns/1ps
module unit_timer
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic [2:0] field,
    input wire logic tick,
    // status
    output logic busy_q,
    output logic done_q
);

    logic [7:0] count_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                count_q <= uv_fault_pkg::TIMER_ONE << field;
                busy_q <= 1'b1;
            end
            else if (busy_q && tick)
            begin
                if (count_q == uv_fault_pkg::TIMER_ONE)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                count_q <= count_q - uv_fault_pkg::TIMER_ONE;
            end
        end
    end

endmodule : unit_timer

// [core/linear_compare.sv]
// Purpose: compares an input voltage sample against both thresholds
// Assumes: all three values are in 16-bit linear format
// Notes: flags hold between samples
`timescale 1ns/1ps
module linear_compare
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // sample and thresholds
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    input wire logic [15:0] warn_threshold,
    input wire logic [15:0] fault_threshold,
    // results
    output logic below_warn_q,
    output logic below_fault_q,
    output logic seen_q
);

    function automatic logic signed [47:0] to_fixed(input logic [15:0] v);
        logic signed [4:0] e;
        logic signed [10:0] m;
        logic signed [47:0] x;
        e = v[uv_fault_pkg::LIN_EXP_HI:uv_fault_pkg::LIN_EXP_LO];
        m = v[uv_fault_pkg::LIN_MANT_HI:uv_fault_pkg::LIN_MANT_LO];
        x = 48'(m) <<< uv_fault_pkg::LIN_FRAC_BITS;
        if (e[4])
            x = x >>> 5'(-e);
        else
            x = x <<< e[3:0];
        return x;
    endfunction : to_fixed

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            below_warn_q <= 1'b0;
            below_fault_q <= 1'b0;
            seen_q <= 1'b0;
        end
        else if (sample_valid)
        begin
            below_warn_q <= to_fixed(sample) < to_fixed(warn_threshold);
            below_fault_q <= to_fixed(sample) < to_fixed(fault_threshold);
            seen_q <= 1'b1;
        end
    end

endmodule : linear_compare

// [testbench/uv_host_model.sv]
// Purpose: management host that issues decoded register commands
// Assumes: one command per call, answer one cycle after it is taken
// Notes: idle code and data lines carry the inverse of the last request
`timescale 1ns/1ps
module uv_host_model
(
    // clock
    input wire logic clk_sys,
    // command port
    output uv_fault_pkg::cmd_t cmd,
    input wire uv_fault_pkg::rsp_t rsp_q
);
    initial cmd = '0;

    // called just after an edge; returns just after the answer edge
    task automatic access(input logic write, input logic [7:0] code,
        input logic [15:0] wdata, output uv_fault_pkg::rsp_t got);
        cmd = {1'b1, write, code, wdata};
        @(posedge clk_sys);
        #1;
        cmd = {1'b0, 1'b0, ~code, ~wdata};
        // answer stands from the taking edge to the next one
        got = rsp_q;
        @(posedge clk_sys);
        #1;
    endtask : access
endmodule : uv_host_model

// [testbench/uv_fault_handler_props.sv]
// Purpose: port assertions of the low-voltage fault handler
// Assumes: one clock domain, rst asynchronous active high
// Notes: the action byte is shadowed from observed writes
`timescale 1ns/1ps
module uv_fault_handler_props
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // command port
    input wire uv_fault_pkg::cmd_t cmd,
    input wire uv_fault_pkg::rsp_t rsp_q,
    // on/off and clearing
    input wire logic ctrl_pin,
    input wire logic operation_on,
    input wire logic clear_faults,
    input wire logic status_clear,
    input wire logic ratio_mode_enable,
    // outputs
    input wire logic output_enable_q,
    input wire logic fault_flag_q,
    input wire logic latched_off_q,
    input wire logic ratio_low_input_q
);
    logic [7:0] act_q;
    logic [2:0] pin_cnt_q;
    logic known;
    logic run_ok;

    assign known = cmd.code inside {8'h58, 8'h59, 8'h5a};
    // pin filter has settled and both run requests are high
    assign run_ok = (pin_cnt_q >= 3'h4) && operation_on;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            act_q <= 8'h00;
        else if (cmd.valid && cmd.write && cmd.code == 8'h5a)
            act_q <= cmd.wdata[7:0];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pin_cnt_q <= 3'h0;
        else if (!ctrl_pin)
            pin_cnt_q <= 3'h0;
        else if (pin_cnt_q != 3'h7)
            pin_cnt_q <= pin_cnt_q + 3'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_rsp_timing: assert property (cmd.valid |=> rsp_q.valid)
        else $error("no answer one cycle after command");
    a_rsp_cause: assert property (rsp_q.valid |-> $past(cmd.valid))
        else $error("answer without command");
    a_ack_known: assert property (cmd.valid && known |=> rsp_q.ack)
        else $error("known register not acknowledged");
    a_refuse_unknown: assert property (
        cmd.valid && !known |=> !rsp_q.ack && rsp_q.rdata == 16'h0000)
        else $error("unknown register answered");
    a_ignore_runs: assert property (
        act_q[7:6] == 2'h0 && output_enable_q && run_ok |=> output_enable_q)
        else $error("output dropped while fault ignored");
    a_latch_off: assert property (latched_off_q |-> !output_enable_q)
        else $error("output on while latched");
    a_latch_holds: assert property (
        latched_off_q && !clear_faults && !status_clear && run_ok |=> latched_off_q)
        else $error("latch released without clear");
    a_disable_now: assert property (
        $rose(fault_flag_q) && act_q[7:6] == 2'h2 |-> ##[0:1] !output_enable_q)
        else $error("output not disabled on fault");
    a_no_retry_latch: assert property (
        $rose(fault_flag_q) && act_q[7:3] == 5'h10 && $past(output_enable_q)
        |-> ##[0:2] latched_off_q)
        else $error("no latch with retry off");
    a_ratio_gate: assert property (ratio_low_input_q |-> $past(ratio_mode_enable))
        else $error("ratio signal without enable");
    a_off_request: assert property (output_enable_q |-> $past(operation_on))
        else $error("output on without run request");

    c_latched: cover property ($rose(latched_off_q));
    c_refused: cover property (rsp_q.valid && !rsp_q.ack);
    c_ratio: cover property (ratio_low_input_q);
    c_restart: cover property ($rose(output_enable_q) && act_q[7:6] == 2'h2);
endmodule : uv_fault_handler_props

bind uv_fault_handler uv_fault_handler_props u_props (.clk_sys(clk_sys), .rst(rst), .cmd(cmd),
    .rsp_q(rsp_q), .ctrl_pin(ctrl_pin), .operation_on(operation_on),
    .clear_faults(clear_faults), .status_clear(status_clear),
    .ratio_mode_enable(ratio_mode_enable), .output_enable_q(output_enable_q),
    .fault_flag_q(fault_flag_q), .latched_off_q(latched_off_q),
    .ratio_low_input_q(ratio_low_input_q));

// [testbench/testbench.sv]
// Purpose: self-checking bench of the low-voltage fault handler
// Assumes: thresholds in linear format with exponent zero
// Notes: each time unit is a hand-made time_tick pulse
`timescale 1ns/1ps
module testbench;
    logic clk_sys;
    logic rst;
    uv_fault_pkg::cmd_t cmd;
    uv_fault_pkg::rsp_t rsp_q;
    logic sample_valid;
    logic [15:0] sample;
    logic time_tick;
    logic ctrl_pin;
    logic operation_on;
    logic clear_faults;
    logic status_clear;
    logic ratio_mode_enable;
    logic output_enable_q;
    logic warn_flag_q;
    logic fault_flag_q;
    logic latched_off_q;
    logic ratio_low_input_q;
    int bad_count;
    int checks_done;
    // 50 V normal, 44 V below warning, 32 V below fault
    localparam logic [15:0] V_OK = 16'h0032;
    localparam logic [15:0] V_WARN = 16'h002c;
    localparam logic [15:0] V_FAULT = 16'h0020;

    uv_host_model host (.clk_sys(clk_sys), .cmd(cmd), .rsp_q(rsp_q));

    uv_fault_handler DUT (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .rsp_q(rsp_q),
        .sample_valid(sample_valid), .sample(sample), .time_tick(time_tick),
        .ctrl_pin(ctrl_pin), .operation_on(operation_on), .clear_faults(clear_faults),
        .status_clear(status_clear), .ratio_mode_enable(ratio_mode_enable),
        .output_enable_q(output_enable_q), .warn_flag_q(warn_flag_q),
        .fault_flag_q(fault_flag_q), .latched_off_q(latched_off_q),
        .ratio_low_input_q(ratio_low_input_q));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        uv_fault_pkg::rsp_t got;
        host.access(1'b1, code, data, got);
    endtask : wr

    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ack);
        uv_fault_pkg::rsp_t got;
        host.access(1'b0, code, 16'h0000, got);
        check("read ack", got.ack, ack);
        check("read data", got.rdata, exp);
    endtask : rd

    task automatic put_sample(input logic [15:0] v);
        sample_valid = 1'b1;
        sample = v;
        cyc(1);
        sample_valid = 1'b0;
        sample = ~v;
        cyc(4);
    endtask : put_sample

    task automatic tick(input int n);
        repeat (n)
        begin
            time_tick = 1'b1;
            cyc(1);
            time_tick = 1'b0;
            cyc(3);
        end
    endtask : tick

    task automatic clear(input logic sel);
        if (sel)
            status_clear = 1'b1;
        else
            clear_faults = 1'b1;
        cyc(1);
        status_clear = 1'b0;
        clear_faults = 1'b0;
        cyc(3);
    endtask : clear

    task automatic wait_on();
        int i;
        i = 0;
        while (output_enable_q !== 1'b1 && i < 50)
        begin
            cyc(1);
            i++;
        end
        if (i == 50)
        begin
            bad_count++;
            close_out();
        end
    endtask : wait_on

    task automatic recover(input logic sel);
        put_sample(V_OK);
        clear(sel);
        wait_on();
        check("latched", latched_off_q, 1'b0);
    endtask : recover

    initial
    begin
        bad_count = 0;
        checks_done = 0;
        rst = 1'b1;
        sample_valid = 1'b0;
        sample = V_OK;
        time_tick = 1'b0;
        ctrl_pin = 1'b0;
        operation_on = 1'b0;
        clear_faults = 1'b0;
        status_clear = 1'b0;
        ratio_mode_enable = 1'b0;
        cyc(12);
        rst = 1'b0;
        cyc(1);
        rd(8'h58, 16'h0000, 1'b1);
        rd(8'h59, 16'h0000, 1'b1);
        rd(8'h5a, 16'h0000, 1'b1);
        wr(8'h58, 16'h0030);
        wr(8'h59, 16'h0028);
        wr(8'h5a, 16'h12a5);
        rd(8'h58, 16'h0030, 1'b1);
        rd(8'h59, 16'h0028, 1'b1);
        rd(8'h5a, 16'h00a5, 1'b1);
        rd(8'h5b, 16'h0000, 1'b0);
        wr(8'h5a, 16'h0000);
        ctrl_pin = 1'b1;
        operation_on = 1'b1;
        put_sample(V_OK);
        wait_on();
        ratio_mode_enable = 1'b1;
        put_sample(V_WARN);
        check("warn", warn_flag_q, 1'b1);
        check("fault", fault_flag_q, 1'b0);
        check("ratio", ratio_low_input_q, 1'b1);
        ratio_mode_enable = 1'b0;
        cyc(2);
        check("ratio off", ratio_low_input_q, 1'b0);
        put_sample(V_FAULT);
        check("fault", fault_flag_q, 1'b1);
        cyc(20);
        check("ignored", output_enable_q, 1'b1);
        put_sample(V_OK);
        clear(1'b0);
        check("flags", {warn_flag_q, fault_flag_q}, 2'h0);
        // latch-off and no-retry, released by each kind of clear
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h5a, k ? 16'h00c0 : 16'h0080);
            put_sample(V_FAULT);
            check("off", output_enable_q, 1'b0);
            check("latched", latched_off_q, 1'b1);
            recover(k[0]);
        end
        wr(8'h5a, 16'h00c0);
        put_sample(V_FAULT);
        put_sample(V_OK);
        operation_on = 1'b0;
        cyc(3);
        operation_on = 1'b1;
        wait_on();
        // run on for four units, then shut down for good
        wr(8'h5a, 16'h0042);
        put_sample(V_FAULT);
        tick(3);
        check("delay run", output_enable_q, 1'b1);
        tick(1);
        check("delay end", output_enable_q, 1'b0);
        check("latched", latched_off_q, 1'b1);
        recover(1'b0);
        // retry counts 1..6, attempts two units apart
        for (int n = 1; n < 7; n++)
        begin
            wr(8'h5a, {8'h00, 2'h2, n[2:0], 3'h1});
            put_sample(V_FAULT);
            tick(2 * n - 1);
            check("retrying", latched_off_q, 1'b0);
            tick(1);
            check("retries spent", latched_off_q, 1'b1);
            recover(1'b0);
        end
        wr(8'h5a, 16'h00b8);
        put_sample(V_FAULT);
        tick(9);
        check("endless", {output_enable_q, latched_off_q}, 2'h0);
        put_sample(V_OK);
        tick(1);
        check("restart", output_enable_q, 1'b1);
        close_out();
    end
endmodule : testbench
